//--- inc/rst_clk_pkg.sv
// constants, carriers and decode helpers for the reset and main clock manager
// assumes one 100 MHz oscillator clock (sys_clk) drives the whole block
// Function
// [R1] reset starts from the external pin, power-on detect or watchdog underflow
// [R2] after reset the CPU fetches its start address from FFFEh and FFFFh
// [R3] reset pin is a sensed input and an open-drain, pulled-up, low-only output
// [R4] internal reset sources drive the pin low through the first two phases; for watchdog the code drives it in the delay phase only
// [R5] watchdog underflow reset uses a shortened two-phase sequence
// [R6] reset condition lasts 4096 CPU clocks and shows low on the pin
// [R7] external requests hold the pin low for at least 1.5 CPU clocks
// [R8] after power-on timing the device stays in reset while the pin is low
// [R9] after any reset or halt exit wait 4096 CPU clocks before running code; watchdog reset skips this wait, going from delay to extend
// [R10] CPU prescaler is steered by slow mode select and two prescale bits
// [R11] time-base counter has four periods, two select bits, enable and flag
// [R12] clock-out enable puts oscillator divided by two on a port pin
// [R13] normal mode divides by 2; slow codes 00..11 divide by 4,8,16,32
// [R14] time-base counts 32000,64000,160000,400000; new choice applies at period end
// [R15] period end sets the time-base flag; reading control/status clears it
// [R16] external reset pin is synchronised to the clock before use
package rst_clk_pkg;

   // register map
   localparam logic [7:0] CTRL_STATUS_OFS = 8'h26;
   localparam logic [7:0] MISC_TWO_OFS    = 8'h28;
   localparam logic [7:0] EVT_STATUS_OFS  = 8'h29;
   localparam logic [7:0] EVT_MASK_OFS    = 8'h2A;
   localparam logic [7:0] CTRL_RESET      = 8'h00;
   localparam logic [3:0] EVT_RESET       = 4'h0;

   // field positions
   localparam int CLK_OUT_EN_BIT = 0;
   localparam int EVT_TB         = 0;
   localparam int EVT_EXT        = 1;
   localparam int EVT_POR        = 2;
   localparam int EVT_WDG        = 3;

   // cycle counts
   localparam int RESET_CPU_CYCLES_DEF = 4096;
   localparam int STAB_CPU_CYCLES_DEF  = 4096;
   localparam int TB_COUNT0_DEF        = 32000;
   localparam int TB_COUNT1_DEF        = 64000;
   localparam int TB_COUNT2_DEF        = 160000;
   localparam int TB_COUNT3_DEF        = 400000;
   localparam logic [1:0] PIN_SETTLE_CYCLES = 2'h3;

   // prescaler terminal values (divide ratio minus one)
   localparam logic [4:0] DIV_NORMAL = 5'h01;
   localparam logic [4:0] DIV_SLOW0  = 5'h03;
   localparam logic [4:0] DIV_SLOW1  = 5'h07;
   localparam logic [4:0] DIV_SLOW2  = 5'h0F;
   localparam logic [4:0] DIV_SLOW3  = 5'h1F;

   // reset vector
   localparam logic [15:0] RESET_VEC_HI_ADDR = 16'hFFFE;
   localparam logic [15:0] RESET_VEC_LO_ADDR = 16'hFFFF;

   typedef struct packed {
      logic       slow_mode_select;
      logic       cpu_prescale_sel_hi;
      logic       cpu_prescale_sel_lo;
      logic       reserved;
      logic       timebase_sel_hi;
      logic       timebase_sel_lo;
      logic       timebase_irq_enable;
      logic       timebase_irq_flag;
   } main_clock_ctrl_status_t;

   typedef struct packed {
      logic [7:0] addr;
      logic [7:0] wdata;
      logic       wr;
      logic       rd;
   } reg_req_t;

   typedef struct packed {
      logic        valid;
      logic [15:0] addr;
   } vec_fetch_t;

   typedef enum logic [2:0] {
      ST_RUN, ST_DELAY, ST_STAB, ST_EXTEND, ST_VEC_HI, ST_VEC_LO, ST_HALT_STAB
   } seq_state_t;

   typedef enum logic [1:0] {SRC_EXT, SRC_POR, SRC_WDG} reset_src_t;

   function automatic logic [4:0] cpu_div_limit(input main_clock_ctrl_status_t c);
      logic [4:0] lim;
      lim = DIV_NORMAL;
      if (c.slow_mode_select) begin
         case ({c.cpu_prescale_sel_hi, c.cpu_prescale_sel_lo})
            2'b00:   lim = DIV_SLOW0;
            2'b01:   lim = DIV_SLOW1;
            2'b10:   lim = DIV_SLOW2;
            default: lim = DIV_SLOW3;
         endcase
      end
      return lim;
   endfunction : cpu_div_limit

endpackage : rst_clk_pkg

//--- verilog/timebase_counter.sv
// periodic time-base tick derived straight from the oscillator clock
// assumes sel comes from a register; tick is a one-cycle registered pulse
`timescale 1ns/1ns
`default_nettype none
module timebase_counter
   import rst_clk_pkg::*;
#(
   parameter int TB_COUNT0 = TB_COUNT0_DEF,
   parameter int TB_COUNT1 = TB_COUNT1_DEF,
   parameter int TB_COUNT2 = TB_COUNT2_DEF,
   parameter int TB_COUNT3 = TB_COUNT3_DEF
) (
   // clock and reset
   input  wire logic       sys_clk,
   input  wire logic       rst,
   // period select and tick
   input  wire logic [1:0] sel,
   output logic            tick
);

   typedef struct packed {
      logic [18:0] cnt;
      logic [1:0]  cur_sel;
      logic        tick;
   } tb_state_t;

   tb_state_t st_q;
   tb_state_t st_d;

   function automatic logic [18:0] period_last(input logic [1:0] s);
      case (s)
         2'b00:   period_last = 19'(TB_COUNT0 - 1);
         2'b01:   period_last = 19'(TB_COUNT1 - 1);
         2'b10:   period_last = 19'(TB_COUNT2 - 1);
         default: period_last = 19'(TB_COUNT3 - 1);
      endcase
   endfunction : period_last

   always_comb begin
      st_d      = st_q;
      st_d.tick = 1'b0;
      if (st_q.cnt >= period_last(st_q.cur_sel)) begin    // [R11]
         st_d.cnt     = 19'h0_0000;
         st_d.tick    = 1'b1;
         st_d.cur_sel = sel;                               // [R14]
      end else begin
         st_d.cnt = st_q.cnt + 19'h0_0001;
      end
   end

   always_ff @(posedge sys_clk) begin
      if (rst) begin
         st_q <= '0;
      end else begin
         st_q <= st_d;
      end
   end

   assign tick = st_q.tick;

endmodule : timebase_counter
`default_nettype wire

//--- verilog/reset_clock_manager.sv
// reset sequencer, CPU clock prescaler, time-base interrupt and clock output
// assumes reset pin input is merely level-synchronous; board resolves the open-drain wire
//
// The plain strobed port and the placing of the registers are this design's own decisions.
`timescale 1ns/1ns
`default_nettype none
module reset_clock_manager
   import rst_clk_pkg::*;
#(
   parameter int RESET_CPU_CYCLES = RESET_CPU_CYCLES_DEF,
   parameter int STAB_CPU_CYCLES  = STAB_CPU_CYCLES_DEF,
   parameter int TB_COUNT0        = TB_COUNT0_DEF,
   parameter int TB_COUNT1        = TB_COUNT1_DEF,
   parameter int TB_COUNT2        = TB_COUNT2_DEF,
   parameter int TB_COUNT3        = TB_COUNT3_DEF
) (
   // clock and reset
   input  wire logic       sys_clk,
   input  wire logic       rst,
   // internal reset sources and halt
   input  wire logic       por_pulse,
   input  wire logic       wdg_underflow,
   input  wire logic       halt_exit,
   // open-drain reset pin
   input  wire logic       rst_pin_in,
   output logic            rst_pin_out,
   output logic            rst_pin_oe,
   // CPU side
   output logic            cpu_reset,
   output logic            cpu_hold,
   output logic            cpu_clk_en,
   output vec_fetch_t      vec_fetch,
   // clock output pin
   output logic            clk_out,
   output logic            clk_out_oe,
   // register port
   input  wire reg_req_t   reg_req,
   output logic [7:0]      reg_rdata,
   // interrupt
   output logic            irq
);

   typedef struct packed {
      seq_state_t              state;
      reset_src_t              src;
      logic [12:0]             cnt;
      logic [4:0]              pre_cnt;
      logic                    cpu_en;
      logic                    pin_s1;
      logic                    pin_s2;
      logic [1:0]              settle;
      logic                    pin_oe;
      logic                    cpu_reset;
      logic                    cpu_hold;
      vec_fetch_t              vec;
      main_clock_ctrl_status_t ctrl;
      logic                    clk_out_en;
      logic                    clk_out;
      logic [3:0]              evt;
      logic [3:0]              mask;
      logic [7:0]              rdata;
      logic                    irq;
   } mgr_state_t;

   mgr_state_t st_q;
   mgr_state_t st_d;
   logic       tb_tick;

   // the pin level counts only while we do not pull it and our own echo has died away
   function automatic logic pin_trusted(input logic oe, input logic [1:0] settle);
      return !oe && (settle == 2'h0);
   endfunction : pin_trusted

   // last CPU clock of a counted phase
   function automatic logic phase_last(input logic en, input logic [12:0] cnt, input int cycles);
      return en && (cnt == 13'(cycles - 1));
   endfunction : phase_last

   // states in which the reset condition stands
   function automatic logic in_reset(input seq_state_t s);
      return (s == ST_DELAY) || (s == ST_STAB) || (s == ST_EXTEND);
   endfunction : in_reset

   timebase_counter #(
      .TB_COUNT0 (TB_COUNT0),
      .TB_COUNT1 (TB_COUNT1),
      .TB_COUNT2 (TB_COUNT2),
      .TB_COUNT3 (TB_COUNT3)
   ) u_timebase (
      .sys_clk (sys_clk),
      .rst     (rst),
      .sel     ({st_q.ctrl.timebase_sel_hi, st_q.ctrl.timebase_sel_lo}),
      .tick    (tb_tick)
   );

   always_comb begin
      logic       ext_low;
      logic       ext_req;
      logic       wdg_req;
      logic       start;
      logic       last_reset;
      logic       last_stab;
      ext_low    = 1'b0;
      ext_req    = 1'b0;
      wdg_req    = 1'b0;
      start      = 1'b0;
      last_reset = 1'b0;
      last_stab  = 1'b0;
      st_d       = st_q;

      // CPU clock enable from the prescaler
      if (st_q.pre_cnt >= cpu_div_limit(st_q.ctrl)) begin   // [R10] [R13]
         st_d.pre_cnt = 5'h00;
         st_d.cpu_en  = 1'b1;
      end else begin
         st_d.pre_cnt = st_q.pre_cnt + 5'h01;
         st_d.cpu_en  = 1'b0;
      end

      // reset pin synchroniser and settle window after our own drive
      st_d.pin_s1 = rst_pin_in;                             // [R16]
      st_d.pin_s2 = st_q.pin_s1;                            // [R16]
      if (st_q.pin_oe) begin
         st_d.settle = PIN_SETTLE_CYCLES;
      end else if (st_q.settle != 2'h0) begin
         st_d.settle = st_q.settle - 2'h1;
      end
      // the pin's own echo is ignored while we drive and shortly after
      ext_low = !st_q.pin_s2 && pin_trusted(st_q.pin_oe, st_q.settle);  // [R3] [R7]

      last_reset = phase_last(st_q.cpu_en, st_q.cnt, RESET_CPU_CYCLES);
      last_stab  = phase_last(st_q.cpu_en, st_q.cnt, STAB_CPU_CYCLES);

      // sequence
      case (st_q.state)
         ST_RUN: begin
            if (halt_exit) begin
               st_d.state = ST_HALT_STAB;                   // [R9]
               st_d.cnt   = 13'h0000;
            end
         end
         ST_DELAY: begin
            if (last_reset) begin                           // [R6]
               st_d.cnt   = 13'h0000;
               st_d.state = (st_q.src == SRC_WDG) ? ST_EXTEND : ST_STAB;  // [R5]
            end else if (st_q.cpu_en) begin
               st_d.cnt = st_q.cnt + 13'h0001;
            end
         end
         ST_STAB: begin
            if (last_stab) begin                            // [R9]
               st_d.cnt   = 13'h0000;
               st_d.state = ST_EXTEND;
            end else if (st_q.cpu_en) begin
               st_d.cnt = st_q.cnt + 13'h0001;
            end
         end
         ST_EXTEND: begin
            // leave only once the board has let go of the pin
            if (st_q.pin_s2 && pin_trusted(st_q.pin_oe, st_q.settle)) begin  // [R8]
               st_d.state = ST_VEC_HI;
            end
         end
         ST_VEC_HI: begin
            st_d.state = ST_VEC_LO;                         // [R2]
         end
         ST_VEC_LO: begin
            st_d.state = ST_RUN;                            // [R2]
         end
         ST_HALT_STAB: begin
            // cpu held but not reset while the oscillator settles
            if (last_stab) begin                            // [R9]
               st_d.cnt   = 13'h0000;
               st_d.state = ST_RUN;
            end else if (st_q.cpu_en) begin
               st_d.cnt = st_q.cnt + 13'h0001;
            end
         end
         default: begin
            st_d.state = ST_DELAY;
            st_d.cnt   = 13'h0000;
         end
      endcase

      // register writes
      if (reg_req.wr) begin
         case (reg_req.addr)
            CTRL_STATUS_OFS: begin
               st_d.ctrl.slow_mode_select    = reg_req.wdata[7];
               st_d.ctrl.cpu_prescale_sel_hi = reg_req.wdata[6];
               st_d.ctrl.cpu_prescale_sel_lo = reg_req.wdata[5];
               st_d.ctrl.timebase_sel_hi     = reg_req.wdata[3];
               st_d.ctrl.timebase_sel_lo     = reg_req.wdata[2];
               st_d.ctrl.timebase_irq_enable = reg_req.wdata[1];
            end
            MISC_TWO_OFS: begin
               st_d.clk_out_en = reg_req.wdata[CLK_OUT_EN_BIT];
            end
            EVT_MASK_OFS: begin
               st_d.mask = reg_req.wdata[3:0];
            end
            default: begin
            end
         endcase
      end

      // register reads: data stand for one cycle, flags clear on read
      st_d.rdata = 8'h00;
      if (reg_req.rd) begin
         case (reg_req.addr)
            CTRL_STATUS_OFS: begin
               st_d.rdata                  = st_q.ctrl;
               st_d.ctrl.timebase_irq_flag = 1'b0;          // [R15]
            end
            MISC_TWO_OFS: begin
               st_d.rdata[CLK_OUT_EN_BIT] = st_q.clk_out_en;
            end
            EVT_STATUS_OFS: begin
               st_d.rdata = {4'h0, st_q.evt};
               st_d.evt   = EVT_RESET;
            end
            EVT_MASK_OFS: begin
               st_d.rdata = {4'h0, st_q.mask};
            end
            default: begin
            end
         endcase
      end
      st_d.ctrl.reserved = 1'b0;

      // reset sources, power-on first
      wdg_req = wdg_underflow && (st_q.state == ST_RUN || st_q.state == ST_HALT_STAB);
      ext_req = ext_low && (st_q.state != ST_DELAY) && (st_q.state != ST_EXTEND);
      start   = por_pulse || wdg_req || ext_req;            // [R1]
      // a new power-on restarts the count even mid-sequence
      if (start) begin
         st_d.state      = ST_DELAY;
         st_d.cnt        = 13'h0000;
         st_d.ctrl       = CTRL_RESET;
         st_d.clk_out_en = 1'b0;
         st_d.mask       = EVT_RESET;
         if (por_pulse) begin
            st_d.src          = SRC_POR;
            st_d.evt[EVT_POR] = 1'b1;
         end else if (wdg_req) begin
            st_d.src          = SRC_WDG;
            st_d.evt[EVT_WDG] = 1'b1;
         end else begin
            st_d.src          = SRC_EXT;
            st_d.evt[EVT_EXT] = 1'b1;
         end
      end

      // time-base period end sets both flags; set beats a same-cycle clear
      if (tb_tick) begin
         st_d.ctrl.timebase_irq_flag = 1'b1;                // [R15]
         st_d.evt[EVT_TB]            = 1'b1;
      end

      // outputs
      // pin pulled low in the delay phase for every source, in stabilise for internal ones
      st_d.pin_oe    = (st_d.state == ST_DELAY)                              // [R6]
                     || (st_d.state == ST_STAB && st_d.src != SRC_EXT);       // [R4]
      st_d.cpu_reset = in_reset(st_d.state);
      st_d.cpu_hold  = (st_d.state != ST_RUN);
      st_d.vec.valid = (st_d.state == ST_VEC_HI) || (st_d.state == ST_VEC_LO);
      st_d.vec.addr  = (st_d.state == ST_VEC_LO) ? RESET_VEC_LO_ADDR : RESET_VEC_HI_ADDR;  // [R2]
      st_d.clk_out   = st_d.clk_out_en ? !st_q.clk_out : 1'b0;                // [R12]
      st_d.irq       = (|(st_d.evt & st_d.mask))
                     || (st_d.ctrl.timebase_irq_flag && st_d.ctrl.timebase_irq_enable);  // [R11]
   end

   always_ff @(posedge sys_clk) begin
      if (rst) begin
         // rst counts as a power-on: the pin is pulled low from the first edge
         st_q              <= '0;
         st_q.state        <= ST_DELAY;
         st_q.src          <= SRC_POR;
         st_q.pin_s1       <= 1'b1;
         st_q.pin_s2       <= 1'b1;
         st_q.pin_oe       <= 1'b1;
         st_q.cpu_reset    <= 1'b1;
         st_q.cpu_hold     <= 1'b1;
         st_q.vec.addr     <= RESET_VEC_HI_ADDR;
         st_q.evt[EVT_POR] <= 1'b1;
      end else begin
         st_q <= st_d;
      end
   end

   // open-drain: the pin is only ever pulled low
   assign rst_pin_out = 1'b0;                               // [R3]
   assign rst_pin_oe  = st_q.pin_oe;
   assign cpu_reset   = st_q.cpu_reset;
   assign cpu_hold    = st_q.cpu_hold;
   assign cpu_clk_en  = st_q.cpu_en;
   assign vec_fetch   = st_q.vec;
   assign clk_out     = st_q.clk_out;
   assign clk_out_oe  = st_q.clk_out_en;
   assign reg_rdata   = st_q.rdata;
   assign irq         = st_q.irq;

endmodule : reset_clock_manager
`default_nettype wire

//--- testbench/rcm_chk.sv
// port assertions for the reset and main clock manager
// assumes it is bound onto reset_clock_manager and sees only its ports
`timescale 1ns/1ns
`default_nettype none
module rcm_chk
   import rst_clk_pkg::*;
(
   // clock and reset
   input wire logic       sys_clk,
   input wire logic       rst,
   // reset sources and halt
   input wire logic       por_pulse,
   input wire logic       wdg_underflow,
   input wire logic       halt_exit,
   input wire logic       rst_pin_in,
   // device outputs
   input wire logic       rst_pin_out,
   input wire logic       rst_pin_oe,
   input wire logic       cpu_reset,
   input wire logic       cpu_hold,
   input wire logic       cpu_clk_en,
   input wire vec_fetch_t vec_fetch,
   input wire logic       clk_out,
   input wire logic       clk_out_oe,
   // register port and interrupt
   input wire reg_req_t   reg_req,
   input wire logic [7:0] reg_rdata,
   input wire logic       irq
);
   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (rst);

   chk_pin_drain: assert property (rst_pin_out == 1'b0)
      else $error("reset pin output is not low");
   chk_por_start: assert property (por_pulse |=> cpu_reset && rst_pin_oe && cpu_hold)
      else $error("power-on request did not start a reset");
   chk_wdg_start: assert property (wdg_underflow && !cpu_hold && !por_pulse && !halt_exit
      |=> cpu_reset && rst_pin_oe) else $error("watchdog underflow did not start a reset");
   chk_pin_low_len: assert property ($rose(cpu_reset) |-> (cpu_reset && rst_pin_oe)[*8])
      else $error("reset pin low span too short");
   chk_vec_order: assert property ($rose(vec_fetch.valid) |-> vec_fetch.addr == 16'hFFFE
      ##1 vec_fetch.valid && vec_fetch.addr == 16'hFFFF ##1 !vec_fetch.valid)
      else $error("vector fetch order wrong");
   chk_pin_extend: assert property ((!rst_pin_in && cpu_reset)[*3] |=> cpu_reset)
      else $error("reset left while pin held low");
   chk_halt_hold: assert property (rst_pin_in[*4] ##0 (halt_exit && !cpu_hold && !por_pulse
      && !wdg_underflow) |=> cpu_hold && !cpu_reset) else $error("halt exit did not hold the cpu");
   chk_clk_half: assert property (clk_out_oe[*3] |-> clk_out != $past(clk_out))
      else $error("clock output not toggling");
   chk_rdata_idle: assert property (!$past(reg_req.rd) |-> reg_rdata == 8'h00)
      else $error("read data outside read answer");
   chk_reset_div: assert property (cpu_reset && cpu_clk_en |=> !cpu_clk_en ##1 cpu_clk_en)
      else $error("cpu clock not divided by two in reset");

   cov_vec: cover property (vec_fetch.valid);
   cov_irq: cover property ($rose(irq));
   cov_halt: cover property (halt_exit && !cpu_hold);
endmodule : rcm_chk

bind reset_clock_manager rcm_chk u_chk (
   .sys_clk(sys_clk), .rst(rst), .por_pulse(por_pulse), .wdg_underflow(wdg_underflow),
   .halt_exit(halt_exit), .rst_pin_in(rst_pin_in), .rst_pin_out(rst_pin_out),
   .rst_pin_oe(rst_pin_oe), .cpu_reset(cpu_reset), .cpu_hold(cpu_hold), .cpu_clk_en(cpu_clk_en),
   .vec_fetch(vec_fetch), .clk_out(clk_out), .clk_out_oe(clk_out_oe), .reg_req(reg_req),
   .reg_rdata(reg_rdata), .irq(irq));
`default_nettype wire

//--- testbench/ext_reset_model.sv
// board side of the reset pin: pull-up, reset button and open-drain wire
// assumes press is driven from the bench at rising clock edges
`timescale 1ns/1ns
`default_nettype none
module ext_reset_model #(
   parameter int MIN_LOW = 4
) (
   // clock
   input wire logic sys_clk,
   // button and device drive
   input wire logic press,
   input wire logic dut_out,
   input wire logic dut_oe,
   // resolved pin level
   output logic     pin_level
);
   int low_cnt = 0;
   // a press lasts at least MIN_LOW clocks, above 1.5 cpu clocks
   always @(posedge sys_clk)
      low_cnt <= press ? MIN_LOW : (low_cnt > 0 ? low_cnt - 1 : 0);
   // pull-up wins unless someone pulls low
   assign pin_level = !((dut_oe && !dut_out) || press || low_cnt > 0);
endmodule : ext_reset_model
`default_nettype wire

//--- testbench/reset_and_main_clock_manager_test.sv
// self-checking bench for the reset and main clock manager
// assumes shortened reset and time-base counts set below; stabilise keeps its full length
`timescale 1ns/1ns
`default_nettype none
module reset_and_main_clock_manager_test;
   import rst_clk_pkg::*;
   logic       sys_clk, rst, por_pulse, wdg_underflow, halt_exit, press;
   logic       rst_pin_in, rst_pin_out, rst_pin_oe, cpu_reset, cpu_hold;
   logic       cpu_clk_en, clk_out, clk_out_oe, irq;
   logic [7:0] reg_rdata, c;
   vec_fetch_t vec_fetch;
   reg_req_t   req;
   int         bad_count = 0, check_count = 0, cyc = 0;

   reset_clock_manager #(.RESET_CPU_CYCLES(8), .TB_COUNT0(20),
      .TB_COUNT1(40), .TB_COUNT2(60), .TB_COUNT3(80)) u_dut (
      .sys_clk(sys_clk), .rst(rst), .por_pulse(por_pulse), .wdg_underflow(wdg_underflow),
      .halt_exit(halt_exit), .rst_pin_in(rst_pin_in), .rst_pin_out(rst_pin_out),
      .rst_pin_oe(rst_pin_oe), .cpu_reset(cpu_reset), .cpu_hold(cpu_hold),
      .cpu_clk_en(cpu_clk_en), .vec_fetch(vec_fetch), .clk_out(clk_out),
      .clk_out_oe(clk_out_oe), .reg_req(req), .reg_rdata(reg_rdata), .irq(irq));
   ext_reset_model u_board (.sys_clk(sys_clk), .press(press), .dut_out(rst_pin_out),
      .dut_oe(rst_pin_oe), .pin_level(rst_pin_in));

   initial begin
      sys_clk = 1'b0;
      forever #5 sys_clk = ~sys_clk;
   end
   always @(posedge sys_clk) cyc <= cyc + 1;

   task automatic print_verdict();
      $display("checks %0d mismatches %0d", check_count, bad_count);
      if (bad_count == 0 && check_count > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   endtask : print_verdict

   task automatic cmp(input string what, input logic [15:0] exp, got);
      check_count++;
      if (got !== exp) begin
         bad_count++;
         $display("[FAIL] %s expected %h seen %h", what, exp, got);
      end
   endtask : cmp

   task automatic step(input int n = 1);
      repeat (n) @(posedge sys_clk);
      #1;
   endtask : step

   task automatic reg_wr(input logic [7:0] a, d);
      @(posedge sys_clk);
      req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
      @(posedge sys_clk);
      req.wr <= 1'b0;
   endtask : reg_wr

   task automatic reg_rd(input string what, input logic [7:0] a, exp, m);
      @(posedge sys_clk);
      req <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
      @(posedge sys_clk);
      req.rd <= 1'b0;
      #1;
      cmp(what, {8'h00, exp}, {8'h00, reg_rdata & m});
   endtask : reg_rd

   // runs one reset or halt sequence until the cpu is released
   task automatic run_seq(input string what, input int pulses, rel, nvec, output int q);
      int n, p;
      logic [15:0] v[$];
      p = 0;
      q = 0;
      for (n = 0; n < 9000 && !(n > 4 && cpu_hold === 1'b0); n++) begin
         @(posedge sys_clk);
         if (n == 0) {por_pulse, wdg_underflow, halt_exit} <= 3'b000;
         if (n == rel) press <= 1'b0;
         #1;
         if (cpu_clk_en === 1'b1 && rst_pin_oe === 1'b1) p++;
         if (cpu_clk_en === 1'b1 && cpu_hold === 1'b1 && cpu_reset === 1'b0 && !vec_fetch.valid) q++;
         if (vec_fetch.valid === 1'b1) v.push_back(vec_fetch.addr);
      end
      cmp("cpu released", 16'h0, {15'h0, cpu_hold});
      cmp(what, 16'(pulses), 16'(p));
      cmp("vector count", 16'(nvec), 16'(v.size()));
      if (nvec == 2) begin
         cmp("vector high", 16'hFFFE, v[0]);
         cmp("vector low", 16'hFFFF, v[1]);
      end
   endtask : run_seq

   task automatic meas_div(output int n);
      for (n = 0; n < 40 && cpu_clk_en !== 1'b1; n++) step();
      step();
      for (n = 1; n < 40 && cpu_clk_en !== 1'b1; n++) step();
   endtask : meas_div

   task automatic wait_irq(output int t);
      for (int n = 0; n < 300 && irq !== 1'b1; n++) step();
      cmp("irq within limit", 16'h1, {15'h0, irq});
      t = cyc;
   endtask : wait_irq

   initial begin
      int t0, t1, q;
      {rst, por_pulse, wdg_underflow, halt_exit, press} = 5'b10000;
      req = '0;
      repeat (10) @(posedge sys_clk);
      rst <= 1'b0;
      run_seq("power-on pin pulses", 8 + STAB_CPU_CYCLES_DEF, -1, 2, q);
      reg_rd("power-on event", EVT_STATUS_OFS, 8'h04, 8'hFE);
      reg_rd("event cleared", EVT_STATUS_OFS, 8'h00, 8'hFE);
      $display("test power_on done");
      @(posedge sys_clk);
      {por_pulse, press} <= 2'b11;
      @(posedge sys_clk);
      por_pulse <= 1'b0;
      step(2 * (8 + STAB_CPU_CYCLES_DEF) + 80);
      cmp("held by pin", 16'h0001, {15'h0, cpu_reset});
      run_seq("after pin release", 0, 0, 2, q);
      reg_rd("power-on again", EVT_STATUS_OFS, 8'h04, 8'h04);
      $display("test pin_hold done");
      @(posedge sys_clk);
      wdg_underflow <= 1'b1;
      run_seq("watchdog pin pulses", 8, -1, 2, q);
      reg_rd("watchdog event", EVT_STATUS_OFS, 8'h08, 8'hFE);
      $display("test watchdog done");
      @(posedge sys_clk);
      press <= 1'b1;
      run_seq("external pin pulses", 8, 6, 2, q);
      reg_rd("external event", EVT_STATUS_OFS, 8'h02, 8'hFE);
      $display("test external done");
      @(posedge sys_clk);
      halt_exit <= 1'b1;
      run_seq("halt pin pulses", 0, -1, 0, q);
      cmp("halt stabilise", 16'(STAB_CPU_CYCLES_DEF), 16'(q));
      $display("test halt done");
      for (int i = 0; i < 5; i++) begin
         c = (i == 0) ? 8'h00 : {1'b1, 2'(i - 1), 5'h00};
         reg_wr(CTRL_STATUS_OFS, c | 8'h10);
         reg_rd("control", CTRL_STATUS_OFS, c, 8'hF0);
         meas_div(t0);
         meas_div(t0);
         cmp("cpu divide", 16'(2 << i), 16'(t0));
      end
      reg_wr(CTRL_STATUS_OFS, 8'h00);
      reg_rd("unmapped", 8'h30, 8'h00, 8'hFF);
      $display("test prescale done");
      for (int k = 0; k < 4; k++) begin
         reg_wr(CTRL_STATUS_OFS, {4'h0, 2'(k), 2'b10});
         wait_irq(t0);
         reg_rd("flag", CTRL_STATUS_OFS, 8'h01, 8'h01);
         wait_irq(t0);
         reg_rd("flag", CTRL_STATUS_OFS, 8'h01, 8'h01);
         cmp("irq cleared", 16'h0, {15'h0, irq});
         wait_irq(t1);
         reg_rd("flag", CTRL_STATUS_OFS, 8'h01, 8'h01);
         cmp("period", 16'(20 * (k + 1)), 16'(t1 - t0));
      end
      $display("test timebase done");
      reg_wr(CTRL_STATUS_OFS, 8'h00);
      reg_rd("event clear", EVT_STATUS_OFS, 8'h00, 8'h00);
      step(100);
      cmp("irq disabled", 16'h0, {15'h0, irq});
      reg_rd("flag disabled", CTRL_STATUS_OFS, 8'h01, 8'h01);
      reg_rd("tick event", EVT_STATUS_OFS, 8'h01, 8'hFF);
      reg_wr(EVT_MASK_OFS, 8'h01);
      wait_irq(t0);
      reg_rd("masked event", EVT_STATUS_OFS, 8'h01, 8'h01);
      cmp("irq after clear", 16'h0, {15'h0, irq});
      reg_wr(EVT_MASK_OFS, 8'h00);
      $display("test interrupt done");
      reg_wr(MISC_TWO_OFS, 8'h01);
      step(4);
      c = {6'h0, clk_out_oe, clk_out};
      step();
      cmp("clock out toggle", {14'h0, 2'b10 | {1'b0, ~c[0]}}, {14'h0, clk_out_oe, clk_out});
      reg_wr(MISC_TWO_OFS, 8'h00);
      step(3);
      cmp("clock out off", 16'h0, {14'h0, clk_out_oe, clk_out});
      $display("test clock_out done");
      print_verdict();
   end

   initial begin
      #600000;
      bad_count++;
      print_verdict();
   end
endmodule : reset_and_main_clock_manager_test
`default_nettype wire
